// *** logic/dcp_power_reset_ctrl.sv ***
// Dual codec playback intake, loopback, power-down and reset control
//
// How it works
// - Playback words are 16-bit two's complement
// - Data bit captured on bit clock fall
// - Words arrive MSB first, LSB last
// - Interpolator sends each sample then N-1 zeros
// - Output gain from register 4 and 9
// - Digital loopback feeds recording word to playback
// - Analog loopback feeds playback back to recording
// - Power-down pin keeps serial and control alive
// - Pin power-down clears counters, keeps registers
// - Codec power-down clears counters, analog untouched
// - Codec power-down bits in registers 2, 7
// - Register 14 master bit shuts analog off
// - Driver power-down bits in 13, 11, 14
// - Reset puts every register at default
// - Reset bit in 2 or 7 resets codec
// - Data accepted again from the next frame
// - Reset via 2 restores 1-5 and 15
// - Reset via 7 restores 6-14, 16, 17
// - Frame of 256 bits, sixteen 16-bit slots
// - Serial control only with select pin low
`timescale 1ns/1ps
module dcp_power_reset_ctrl #(
    parameter int OSR = dcp_pkg::OSR_DEFAULT,
    parameter int TICK_DIV = dcp_pkg::TICK_DIV_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic bclk,
    input wire logic frame_sync_pulse,
    input wire logic din,
    input wire logic power_down_pin,
    input wire logic ctrl_sel_n,
    input wire logic [1:0][15:0] adc_word,
    input wire logic [1:0] adc_valid,
    output logic [1:0][15:0] dac_sample,
    output logic [1:0] dac_strobe,
    output logic [5:0] amp_gain1,
    output logic [5:0] amp_gain2,
    output logic speaker_drv_off,
    output logic handset_drv_off,
    output logic headset_drv_off,
    output logic line_drv_off,
    output logic analog_off,
    output logic [1:0] analog_loop,
    output logic [1:0] codec_run
);
    localparam int TW = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);
    localparam logic [4:0] CTRL_IDX [2] =
        '{dcp_pkg::IDX_CODEC1_CTRL, dcp_pkg::IDX_CODEC2_CTRL};
    localparam logic [17:0] GROUP_MASK [2] =
        '{dcp_pkg::GROUP1_MASK, dcp_pkg::GROUP2_MASK};
    localparam logic [3:0] DATA_SLOT [2] =
        '{dcp_pkg::SLOT_CODEC1, dcp_pkg::SLOT_CODEC2};

    // Pin synchronisers: stage one is read only by stage two
    logic [4:0] pin_raw;
    logic [4:0] sync1;
    logic [4:0] sync2;
    assign pin_raw = {ctrl_sel_n, power_down_pin, din, frame_sync_pulse,
                      bclk};

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync1 <= 5'h10;
            sync2 <= 5'h10;
        end else begin
            sync1 <= pin_raw;
            sync2 <= sync1;
        end
    end

    logic bclk_s;
    logic frame_sync_pulse_s;
    logic din_s;
    logic hw_pd;
    logic ctrl_sel_n_s;
    assign bclk_s = sync2[0];
    assign frame_sync_pulse_s = sync2[1];
    assign din_s = sync2[2];
    assign hw_pd = sync2[3];
    assign ctrl_sel_n_s = sync2[4];

    // Serial receiver state
    logic bclk_d;
    logic framed;
    logic [7:0] bit_cnt;
    logic [15:0] shreg;
    logic word_done;
    logic [3:0] word_slot;
    logic [15:0] word;
    logic frame_start;
    logic next_bclk_d;
    logic next_framed;
    logic [7:0] next_bit_cnt;
    logic [15:0] next_shreg;
    logic next_word_done;
    logic [3:0] next_word_slot;
    logic [15:0] next_word;
    logic next_frame_start;
    logic bclk_fall;
    logic [7:0] cur_bit;

    always_comb begin
        next_bclk_d = bclk_s;
        next_framed = framed;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_word_done = 1'b0;
        next_word_slot = word_slot;
        next_word = word;
        next_frame_start = 1'b0;
        bclk_fall = bclk_d & ~bclk_s;
        // A sync seen at a falling edge makes that bit the frame's first
        cur_bit = frame_sync_pulse_s ? 8'h00 : bit_cnt;
        if (bclk_fall) begin
            next_shreg = {shreg[14:0], din_s};
            next_bit_cnt = cur_bit + 8'h01;
            if (frame_sync_pulse_s) begin
                next_framed = 1'b1;
                next_frame_start = 1'b1;
            end
            if (cur_bit[3:0] == 4'hF && (framed || frame_sync_pulse_s)) begin
                next_word_done = 1'b1;
                next_word_slot = cur_bit[7:4];
                next_word = {shreg[14:0], din_s};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bclk_d <= 1'b0;
            framed <= 1'b0;
            bit_cnt <= 8'h00;
            shreg <= 16'h0000;
            word_done <= 1'b0;
            word_slot <= 4'h0;
            word <= 16'h0000;
            frame_start <= 1'b0;
        end else begin
            // Serial side keeps running through pin power-down
            bclk_d <= next_bclk_d;
            framed <= next_framed;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            word_done <= next_word_done;
            word_slot <= next_word_slot;
            word <= next_word;
            frame_start <= next_frame_start;
        end
    end

    // Register file, APB slave and software reset
    logic [7:0] regs [1:17];
    logic [1:0] sw_hold;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic [7:0] next_regs [1:17];
    logic [1:0] next_sw_hold;
    logic [4:0] apb_idx;
    logic apb_ok;
    logic apb_take;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [7:0] wr_data;
    logic [7:0] status;

    always_comb begin
        apb_idx = paddr[6:2];
        apb_ok = (paddr[1:0] == 2'b00) && (paddr[7] == 1'b0) &&
                 (apb_idx != 5'h00) && (apb_idx <= dcp_pkg::IDX_STATUS);
        apb_take = psel & penable & pready;
        status = {2'b00, codec_run, sw_hold, framed, hw_pd};
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_pready = psel & penable & ~pready;
        if (psel && penable && !pready) begin
            next_prdata = 32'h0000_0000;
            next_pslverr = ~apb_ok;
            if (apb_ok && !pwrite) begin
                if (apb_idx == dcp_pkg::IDX_STATUS) begin
                    next_prdata = {24'h000000, status};
                end else begin
                    next_prdata = {24'h000000, regs[apb_idx]};
                end
            end
        end
        // Bus write wins the cycle over a serial control word
        wr_en = 1'b0;
        wr_idx = apb_idx;
        wr_data = pwdata[7:0];
        if (apb_take && pwrite && apb_ok &&
            apb_idx <= dcp_pkg::IDX_LAST_RW) begin
            wr_en = 1'b1;
        end else if (word_done && word_slot == dcp_pkg::SLOT_CTRL &&
                     !ctrl_sel_n_s && word[dcp_pkg::CW_WRITE]) begin
            wr_idx = word[dcp_pkg::CW_IDX_LO +: 5];
            wr_data = word[7:0];
            wr_en = (wr_idx != 5'h00) && (wr_idx <= dcp_pkg::IDX_LAST_RW);
        end
        for (int r = 1; r <= 17; r++) begin
            next_regs[r] = regs[r];
        end
        next_sw_hold = sw_hold;
        // Hold ends at the next frame start; a fresh reset wins
        if (frame_start) begin
            next_sw_hold = 2'b00;
        end
        if (wr_en) begin
            next_regs[wr_idx] = wr_data;
        end
        for (int c = 0; c < 2; c++) begin
            if (wr_en && wr_idx == CTRL_IDX[c] &&
                wr_data[dcp_pkg::BIT_SW_RESET]) begin
                next_sw_hold[c] = 1'b1;
                for (int r = 1; r <= 17; r++) begin
                    if (GROUP_MASK[c][r]) begin
                        next_regs[r] = dcp_pkg::REG_RESET;
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int r = 1; r <= 17; r++) begin
                regs[r] <= dcp_pkg::REG_RESET;
            end
            sw_hold <= 2'b00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            // Pin power-down never touches the registers
            for (int r = 1; r <= 17; r++) begin
                regs[r] <= next_regs[r];
            end
            sw_hold <= next_sw_hold;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Modulator rate enable shared by both interpolators
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [TW-1:0] next_tick_cnt;
    logic next_tick;

    always_comb begin
        next_tick = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? '0 : tick_cnt + 1'b1;
        if (hw_pd) begin
            next_tick_cnt = '0;
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // Per-codec playback path
    logic [1:0] active;
    dcp_codec_if cif [2] ();

    for (genvar c = 0; c < 2; c++) begin : g_codec
        logic [7:0] ctrl;
        logic dig_loop;
        assign ctrl = regs[CTRL_IDX[c]];
        assign dig_loop = ctrl[dcp_pkg::BIT_DIG_LOOP];
        // Counters cleared on either power-down or a pending reset
        assign active[c] = ~ctrl[dcp_pkg::BIT_CODEC_PD] & ~hw_pd &
                           ~sw_hold[c];
        assign cif[c].clear = ~active[c];
        assign cif[c].tick = tick;
        assign cif[c].sample = dig_loop ? adc_word[c] : word;
        assign cif[c].load = active[c] & (dig_loop ? adc_valid[c] :
                             (word_done && word_slot == DATA_SLOT[c]));
        dcp_interp #(.OSR(OSR)) u_interp (
            .mclk(mclk),
            .rst(rst),
            .cif(cif[c])
        );
        assign dac_sample[c] = cif[c].out_sample;
        assign dac_strobe[c] = cif[c].out_strobe;
    end

    // Registered analog controls
    logic [7:0] ana;
    logic [5:0] next_amp_gain1;
    logic [5:0] next_amp_gain2;
    logic next_spk;
    logic next_hnd;
    logic next_hds;
    logic next_line;
    logic next_analog_off;
    logic [1:0] next_analog_loop;

    always_comb begin
        ana = regs[dcp_pkg::IDX_ANALOG];
        next_amp_gain1 = regs[dcp_pkg::IDX_GAIN1][5:0];
        next_amp_gain2 = regs[dcp_pkg::IDX_GAIN2][5:0];
        next_spk = regs[dcp_pkg::IDX_SPK_DRV][dcp_pkg::BIT_DRV_PD];
        next_hnd = regs[dcp_pkg::IDX_HND_DRV][dcp_pkg::BIT_DRV_PD];
        next_hds = ana[dcp_pkg::BIT_HDS_PD];
        next_line = ana[dcp_pkg::BIT_LINE_PD];
        next_analog_off = ana[dcp_pkg::BIT_MASTER_PD] | hw_pd;
        next_analog_loop[0] =
            regs[dcp_pkg::IDX_CODEC1_CTRL][dcp_pkg::BIT_ANA_LOOP];
        next_analog_loop[1] =
            regs[dcp_pkg::IDX_CODEC2_CTRL][dcp_pkg::BIT_ANA_LOOP];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            amp_gain1 <= 6'h00;
            amp_gain2 <= 6'h00;
            speaker_drv_off <= 1'b0;
            handset_drv_off <= 1'b0;
            headset_drv_off <= 1'b0;
            line_drv_off <= 1'b0;
            analog_off <= 1'b0;
            analog_loop <= 2'b00;
            codec_run <= 2'b00;
        end else begin
            amp_gain1 <= next_amp_gain1;
            amp_gain2 <= next_amp_gain2;
            speaker_drv_off <= next_spk;
            handset_drv_off <= next_hnd;
            headset_drv_off <= next_hds;
            line_drv_off <= next_line;
            analog_off <= next_analog_off;
            analog_loop <= next_analog_loop;
            codec_run <= active;
        end
    end
endmodule

// *** logic/dcp_pkg.sv ***
// Shared constants for the dual codec power and reset controller
package dcp_pkg;
    // Register indices; byte address is four times the index
    localparam int REG_NUM = 18;
    localparam logic [4:0] IDX_CODEC1_CTRL = 5'h02;
    localparam logic [4:0] IDX_GAIN1 = 5'h04;
    localparam logic [4:0] IDX_CODEC2_CTRL = 5'h07;
    localparam logic [4:0] IDX_GAIN2 = 5'h09;
    localparam logic [4:0] IDX_SPK_DRV = 5'h0B;
    localparam logic [4:0] IDX_HND_DRV = 5'h0D;
    localparam logic [4:0] IDX_ANALOG = 5'h0E;
    localparam logic [4:0] IDX_STATUS = 5'h12;
    localparam logic [4:0] IDX_LAST_RW = 5'h11;
    // Fields of the codec control registers (2 and 7)
    localparam int BIT_CODEC_PD = 0;
    localparam int BIT_SW_RESET = 1;
    localparam int BIT_DIG_LOOP = 2;
    localparam int BIT_ANA_LOOP = 3;
    // Fields of drivers and analog register
    localparam int BIT_DRV_PD = 0;
    localparam int BIT_HDS_PD = 0;
    localparam int BIT_LINE_PD = 1;
    localparam int BIT_MASTER_PD = 7;
    localparam int GAIN_W = 6;
    // Registers restored by each software reset (bit n = register n)
    localparam logic [17:0] GROUP1_MASK = 18'h0803E;
    localparam logic [17:0] GROUP2_MASK = 18'h37FC0;
    // Value of every register after reset
    localparam logic [7:0] REG_RESET = 8'h00;
    // Serial frame shape
    localparam int FRAME_BITS = 256;
    localparam int SLOT_BITS = 16;
    localparam int SAMPLE_W = 16;
    localparam logic [3:0] SLOT_CTRL = 4'h0;
    localparam logic [3:0] SLOT_CODEC1 = 4'h2;
    localparam logic [3:0] SLOT_CODEC2 = 4'h3;
    // Control word: bit 15 write, bits 12:8 index, bits 7:0 data
    localparam int CW_WRITE = 15;
    localparam int CW_IDX_LO = 8;
    // Defaults of the top parameters
    localparam int OSR_DEFAULT = 64;
    localparam int TICK_DIV_DEFAULT = 4;
endpackage

// *** logic/dcp_codec_if.sv ***
// Link between the controller core and one playback interpolator
`timescale 1ns/1ps
interface dcp_codec_if;
    logic [15:0] sample;
    logic load;
    logic clear;
    logic tick;
    logic [15:0] out_sample;
    logic out_strobe;
    modport ctrl (output sample, output load, output clear, output tick,
                  input out_sample, input out_strobe);
    modport interp (input sample, input load, input clear, input tick,
                    output out_sample, output out_strobe);
endinterface

// *** logic/dcp_interp.sv ***
// Zero-stuffing interpolator for one playback channel
`timescale 1ns/1ps
module dcp_interp #(
    parameter int OSR = dcp_pkg::OSR_DEFAULT
) (
    input wire logic mclk,
    input wire logic rst,
    dcp_codec_if.interp cif
);
    localparam int PW = (OSR > 1) ? $clog2(OSR) : 1;
    localparam logic [PW-1:0] PHASE_LAST = PW'(OSR - 1);

    logic [15:0] hold;
    logic [PW-1:0] phase;
    logic [15:0] out_sample;
    logic out_strobe;
    logic [15:0] next_hold;
    logic [PW-1:0] next_phase;
    logic [15:0] next_out_sample;
    logic next_out_strobe;

    always_comb begin
        next_hold = hold;
        next_phase = phase;
        next_out_sample = out_sample;
        next_out_strobe = 1'b0;
        if (cif.clear) begin
            // Counters cleared; the held word and output word are dropped as well
            next_phase = '0;
            next_hold = 16'h0000;
            next_out_sample = 16'h0000;
        end else begin
            if (cif.tick) begin
                // N output words per input word: sample then N-1 zeros
                next_out_strobe = 1'b1;
                next_out_sample = (phase == '0) ? hold : 16'h0000;
                next_phase = (phase == PHASE_LAST) ? '0 : phase + 1'b1;
            end
            if (cif.load) begin
                next_hold = cif.sample;
                next_phase = '0;
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hold <= 16'h0000;
            phase <= '0;
            out_sample <= 16'h0000;
            out_strobe <= 1'b0;
        end else begin
            hold <= next_hold;
            phase <= next_phase;
            out_sample <= next_out_sample;
            out_strobe <= next_out_strobe;
        end
    end

    assign cif.out_sample = out_sample;
    assign cif.out_strobe = out_strobe;
endmodule

// *** bench/dcp_checker.sv ***
// Port assertions for the dual codec power and reset controller
`timescale 1ns/1ps
module dcp_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic power_down_pin,
    input wire logic [1:0] dac_strobe,
    input wire logic [5:0] amp_gain1,
    input wire logic [5:0] amp_gain2,
    input wire logic speaker_drv_off,
    input wire logic headset_drv_off,
    input wire logic line_drv_off,
    input wire logic analog_off,
    input wire logic [1:0] codec_run
);
    logic wr;
    logic [7:0] wdat;
    logic [7:0] next_wdat;
    assign wr = psel && penable && pready && pwrite;
    // Last written byte, so outputs can be compared a cycle or two later
    always_comb begin
        next_wdat = wdat;
        if (wr) begin
            next_wdat = pwdata[7:0];
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdat <= 8'h00;
        end else begin
            wdat <= next_wdat;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    AST_APB_WAIT: assert property (
        psel && penable && !pready |=> pready)
        else $error("register access not answered");
    AST_GAIN1: assert property (
        wr && paddr == 8'h10 |=> ##[0:1] amp_gain1 == wdat[5:0])
        else $error("gain 1 does not follow its register");
    AST_GAIN2: assert property (
        wr && paddr == 8'h24 |=> ##[0:1] amp_gain2 == wdat[5:0])
        else $error("gain 2 does not follow its register");
    AST_SPK: assert property (
        wr && paddr == 8'h2C |=> ##[0:1] speaker_drv_off == wdat[0])
        else $error("speaker driver off wrong");
    AST_LINE: assert property (
        wr && paddr == 8'h38 |=> ##[0:1]
        {line_drv_off, headset_drv_off} == wdat[1:0])
        else $error("line or headset driver off wrong");
    AST_HW_PD: assert property (
        power_down_pin [*6] |-> analog_off && codec_run == 2'h0)
        else $error("power-down pin not honoured");
    AST_NO_STROBE: assert property (
        (!codec_run[0]) [*3] |-> !dac_strobe[0])
        else $error("stopped codec still strobes");
    AST_SWR1: assert property (
        wr && paddr == 8'h08 && pwdata[1] |=> ##[0:1] amp_gain1 == 6'h00)
        else $error("codec 1 reset keeps gain");
    AST_SWR1_HOLD: assert property (
        wr && paddr == 8'h08 && pwdata[1] |-> ##[1:3] !codec_run[0])
        else $error("codec 1 not held by reset");
    AST_SWR2: assert property (
        wr && paddr == 8'h1C && pwdata[1] |=> ##[0:1]
        amp_gain2 == 6'h00 && !speaker_drv_off)
        else $error("codec 2 reset keeps registers");
    COV_SWR: cover property (wr && paddr == 8'h08 && pwdata[1]);
    COV_PLAY: cover property (dac_strobe[0]);
    COV_PD: cover property ($rose(power_down_pin));
endmodule

bind dcp_power_reset_ctrl dcp_checker dcp_checker_inst (.*);

// *** bench/dcp_host_model.sv ***
// Host serial port model: bit clock, frame sync and data in
`timescale 1ns/1ps
module dcp_host_model (
    input wire logic go,
    input wire logic [15:0] cw,
    input wire logic [15:0] s1,
    input wire logic [15:0] s2,
    output logic busy,
    output logic bclk,
    output logic frame_sync_pulse,
    output logic din
);
    logic [15:0] w;
    initial begin
        busy = 1'b0;
        bclk = 1'b0;
        frame_sync_pulse = 1'b0;
        din = 1'b0;
    end
    // Bit clock stands still between frames
    always @(posedge go) begin
        busy = 1'b1;
        #7;
        for (int i = 0; i < 256; i++) begin
            case (i / 16)
                0: w = cw;
                2: w = s1;
                3: w = s2;
                default: w = 16'h0000;
            endcase
            bclk = 1'b1;
            frame_sync_pulse = (i == 0);
            din = w[15 - i % 16];
            #40;
            bclk = 1'b0;
            #40;
        end
        frame_sync_pulse = 1'b0;
        din = ~din;
        busy = 1'b0;
    end
endmodule

// *** bench/tb_dual_codec_power_reset_control.sv ***
// Testbench for the dual codec power and reset controller
`timescale 1ns/1ps
module tb_dual_codec_power_reset_control;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, bclk, frame_sync_pulse, din, busy, go = 0;
    logic power_down_pin = 0, ctrl_sel_n = 0;
    logic [1:0][15:0] adc_word = 32'h0, dac_sample;
    logic [1:0] adc_valid = 2'h0, dac_strobe, analog_loop, codec_run;
    logic [15:0] cw = 16'h0, s1 = 16'h0, s2 = 16'h0;
    logic [5:0] amp_gain1, amp_gain2;
    logic speaker_drv_off, handset_drv_off, headset_drv_off, line_drv_off;
    logic analog_off;
    logic [15:0] q0[$];
    logic seen2 = 1'b0;
    int mismatches = 0, num_checks = 0;
    dcp_power_reset_ctrl #(.OSR(4), .TICK_DIV(2))
        dcp_power_reset_ctrl_inst (.*);
    dcp_host_model dcp_host_model_inst (.*);
    always #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (dac_strobe[0] === 1'b1) begin
            q0.push_back(dac_sample[0]);
        end
        if (dac_strobe[1] === 1'b1 && dac_sample[1] === 16'h7FFE) begin
            seen2 <= 1'b1;
        end
    end
    task automatic chk(input string n, input logic [31:0] s,
                       input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n == 50) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task automatic frame(input logic [15:0] c, input logic [15:0] a,
                         input logic [15:0] b);
        int n;
        n = 0;
        cw <= c;
        s1 <= a;
        s2 <= b;
        go <= 1'b1;
        q0.delete();
        @(posedge mclk);
        go <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy && n < 6000);
        if (n == 6000) mismatches++;
        repeat (8) @(posedge mclk);
    endtask
    function automatic int at(input logic [15:0] v);
        foreach (q0[i]) begin
            if (q0[i] === v) return i;
        end
        return -1;
    endfunction
    task automatic t_regs();
        for (int i = 1; i < 18; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 8'h00, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b1, 8'h10, 32'h2A);
        apb(1'b1, 8'h24, 32'h15);
        apb(1'b1, 8'h2C, 32'h01);
        apb(1'b1, 8'h34, 32'h01);
        apb(1'b1, 8'h38, 32'h83);
        chk("gains", {amp_gain2, amp_gain1}, 12'h56A);
        chk("drivers", {speaker_drv_off, handset_drv_off, line_drv_off,
            headset_drv_off, analog_off}, 5'h1F);
        apb(1'b1, 8'h38, 32'h00);
        chk("analog on", analog_off, 1'b0);
    endtask
    task automatic t_play();
        int k;
        frame(16'h0000, 16'h8001, 16'h7FFE);
        k = at(16'h8001);
        chk("sample", k >= 0, 1'b1);
        chk("sample 2", seen2, 1'b1);
        for (int j = 1; j < 4; j++) begin
            chk("stuffed zero", q0[k + j], 16'h0000);
        end
    endtask
    task automatic t_ctrl();
        ctrl_sel_n <= 1'b1;
        frame(16'h8411, 16'h0, 16'h0);
        chk("select high", amp_gain1, 6'h2A);
        ctrl_sel_n <= 1'b0;
        frame(16'h0411, 16'h0, 16'h0);
        chk("no write bit", amp_gain1, 6'h2A);
        frame(16'h8411, 16'h0, 16'h0);
        chk("serial write", amp_gain1, 6'h11);
    endtask
    task automatic t_cpd();
        apb(1'b1, 8'h08, 32'h01);
        chk("codec 1 off", {analog_off, codec_run}, 3'h2);
        frame(16'h0, 16'h4321, 16'h0);
        chk("no data", 32'(q0.size()), 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("kept", rd, 32'h1);
        apb(1'b1, 8'h08, 32'h00);
        apb(1'b1, 8'h1C, 32'h01);
        chk("codec 2 off", codec_run, 2'h1);
        apb(1'b1, 8'h1C, 32'h00);
    endtask
    task automatic t_hpd();
        power_down_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        chk("pin down", {analog_off, codec_run}, 3'h4);
        apb(1'b1, 8'h0C, 32'h5A);
        apb(1'b0, 8'h0C, 32'h0);
        chk("bus alive", rd, 32'h5A);
        apb(1'b0, 8'h48, 32'h0);
        chk("status", rd, 32'h03);
        power_down_pin <= 1'b0;
        frame(16'h0, 16'h0, 16'h0);
        frame(16'h0, 16'h0, 16'h0);
        chk("regs kept", amp_gain1, 6'h11);
        frame(16'h0, 16'h2468, 16'h0);
        chk("resumed", at(16'h2468) >= 0, 1'b1);
    endtask
    task automatic t_swr();
        apb(1'b1, 8'h24, 32'h3F);
        apb(1'b1, 8'h3C, 32'h55);
        apb(1'b1, 8'h18, 32'h66);
        apb(1'b1, 8'h08, 32'h02);
        chk("reset 1", {amp_gain2, amp_gain1, codec_run[0]},
            13'h1F80);
        apb(1'b0, 8'h3C, 32'h0);
        chk("reg 15", rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk("reg 3", rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk("reg 6", rd, 32'h66);
        frame(16'h840A, 16'h1357, 16'h0);
        chk("next frame ctrl", amp_gain1, 6'h0A);
        chk("next frame data", at(16'h1357) >= 0, 1'b1);
        apb(1'b1, 8'h1C, 32'h02);
        chk("reset 2", {amp_gain2, speaker_drv_off}, 7'h00);
        apb(1'b0, 8'h18, 32'h0);
        chk("reg 6 reset", rd, 32'h0);
        chk("gain 1 kept", amp_gain1, 6'h0A);
    endtask
    task automatic t_loop();
        apb(1'b1, 8'h08, 32'h04);
        q0.delete();
        adc_word[0] <= 16'h1234;
        adc_valid <= 2'h1;
        @(posedge mclk);
        adc_valid <= 2'h0;
        repeat (20) @(posedge mclk);
        chk("digital loop", at(16'h1234) >= 0, 1'b1);
        apb(1'b1, 8'h08, 32'h08);
        apb(1'b1, 8'h1C, 32'h08);
        chk("analog loop", analog_loop, 2'h3);
    endtask
    task automatic t_rst();
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk("pin reset", {amp_gain1, analog_loop}, 8'h00);
        apb(1'b0, 8'h1C, 32'h0);
        chk("reg 7 reset", rd, 32'h0);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_regs();
        repeat (2500) @(posedge mclk);
        t_play();
        t_ctrl();
        t_cpd();
        t_hpd();
        t_swr();
        t_loop();
        t_rst();
        end_sim();
    end
    // Whole run is near 49000 cycles; this cuts a hang short
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
endmodule
